// >>> rss_pkg.sv
// constants, states and carriers shared by the reset source sequencer.
// assumes a single system clock and an AXI4-Lite register bus.
package rss_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [7:0] CONTROL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] FLAGS_OFFSET = 8'h08;

    // control register fields
    localparam int CTRL_BROWNOUT_BIT = 0;
    localparam int CTRL_T1REQ_BIT = 1;
    localparam int CTRL_T1EN_BIT = 2;
    localparam int CTRL_ITREQ_BIT = 3;
    localparam int CTRL_OTHER_LSB = 4;
    localparam int CTRL_OTHER_MSB = 7;
    // status register fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_STATE_MSB = 3;
    localparam int STAT_CAUSE_LSB = 4;
    localparam int STAT_CAUSE_MSB = 7;
    localparam int STAT_RETAIN_BIT = 8;
    // flags register fields
    localparam int FLAG_SP_LSB = 0;
    localparam int FLAG_SP_MSB = 3;
    localparam int FLAG_EXTINT_BIT = 4;
    localparam int FLAG_BIT_LSB = 8;
    localparam int FLAG_BIT_MSB = 15;

    localparam logic [3:0] SP_INIT = 4'h5;
    localparam logic [7:0] MODULO_INIT = 8'hFF;
    localparam logic [7:0] COUNT_INIT = 8'h00;
    localparam logic [7:0] BIT_WDT_INIT = 8'h40;
    localparam logic [3:0] OTHER_INIT = 4'h0;
    localparam logic [11:0] START_ADDR = 12'h000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // stability wait: timer 1 counts 256 ticks of system clock / 512
    localparam int WAIT_PRESCALE = 512;
    localparam int WAIT_TICKS = 256;
    localparam int WAIT_CYCLES_DEFAULT = WAIT_PRESCALE * WAIT_TICKS;
    localparam int WAIT_CNT_W = 18;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        SEQ_RUN = 4'h1,
        SEQ_HOLD = 4'h2,
        SEQ_WAIT = 4'h4,
        SEQ_INIT = 4'h8
    } rss_state_type;

    typedef struct packed {
        logic stack;
        logic watchdog;
        logic supply;
        logic pin;
    } rss_cause_type;

    typedef struct packed {
        logic [3:0] stackDepthPointer;
        logic timer1RequestFlag;
        logic timer1EnableFlag;
        logic intervalTimerRequestFlag;
        logic extIntFlag;
        logic [3:0] otherControl;
    } rss_ctrl_type;

    typedef struct packed {
        logic [7:0] timer0Modulo;
        logic [7:0] timer1Modulo;
        logic [7:0] timer0Count;
        logic [7:0] timer1Count;
        logic [7:0] basicIntervalTimer;
    } rss_timer_type;
endpackage

// >>> rss_reset_source_sequencer.sv
// reset source collection and start-up sequencing for a small controller.
// assumes synchronous cause inputs and an AXI4-Lite master on the bus.
// Overview of operation
// - four causes: reset pin, supply detect, watchdog overflow, stack fault.
// - pin release starts the clock, then timer 1 stability wait.
// - wait ends after 512 times 256 system clock cycles.
// - supply reset behaves like pin reset, including the wait.
// - watchdog and stack resets skip the stability wait.
// - watchdog or stack reset loads initial state, then fetches at 0000H.
// - pin or supply reset starts at 0000H after the wait.
// - oscillator stopped while reset is asserted.
// - power-on detection asserts reset.
// - supply drop detection asserts reset.
// - hard reset: pointer 5H, timer-1 flags set, interval flag clear.
// - soft reset: pointer 5H, interrupt flag follows pin, rest kept.
// - hard reset in standby keeps data memory and shift registers.
// - modulo FFH, timer 0 cleared; timer 1 cleared on hard reset.
// - watchdog reset loads 40H into the interval timer counter.
// - supply drop reset only while brownout enable is set.
// - stop with operand 0000B enters the post-reset state.
module rss_reset_source_sequencer import rss_pkg::*; #(
    parameter int unsigned WAIT_CYCLES = WAIT_CYCLES_DEFAULT
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic extResetN,
    input wire logic powerOnDetect,
    input wire logic powerDropDetect,
    input wire logic watchdogOverflow,
    input wire logic stackFault,
    input wire logic intPin,
    input wire logic standbyMode,
    input wire logic stopZeroExec,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic coreReset,
    output logic oscStop,
    output logic fetchEnable,
    output logic [11:0] fetchAddr,
    output logic retainData,
    output rss_ctrl_type ctrlFlags,
    output rss_timer_type timerInit
);
    rss_state_type state;
    rss_cause_type causeNow;
    rss_cause_type causeSeen;
    logic brownoutEnable;
    logic stopLatched;
    logic hardNow;
    logic anyNow;
    logic resetReq;
    logic hardSeen;
    logic standbyAtEntry;
    logic waitDone;
    logic awHave;
    logic wHave;
    logic [ADDR_W-1:0] awAddrQ;
    logic [DATA_W-1:0] wDataQ;
    logic [3:0] wStrbQ;
    logic [ADDR_W-1:0] wrAddr;
    logic [DATA_W-1:0] wrData;
    logic wrLane0;
    logic doWrite;
    logic wrControl;
    logic wrStatus;
    logic [2:0] wrSel;

    // one-hot select: bit 0 control, 1 status, 2 flags; zero is unmapped
    function automatic logic [2:0] regSelect(input logic [ADDR_W-1:0] a);
        logic [2:0] sel;
        sel = 3'h0;
        if (a == CONTROL_OFFSET) begin
            sel = 3'h1;
        end else if (a == STATUS_OFFSET) begin
            sel = 3'h2;
        end else if (a == FLAGS_OFFSET) begin
            sel = 3'h4;
        end
        return sel;
    endfunction

    // cause collection
    always_comb begin
        causeNow.pin = !extResetN;
        causeNow.supply = powerOnDetect
            || (powerDropDetect && brownoutEnable);
        causeNow.watchdog = watchdogOverflow;
        causeNow.stack = stackFault;
    end
    assign hardNow = causeNow.pin || causeNow.supply || stopLatched;
    assign anyNow = hardNow || causeNow.watchdog || causeNow.stack;

    // release only after the merged cause has been low for a full clock
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            resetReq <= 1'b1;
        end else begin
            resetReq <= anyNow;
        end
    end

    // stop 0000B holds reset until a pin or supply reset arrives
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stopLatched <= 1'b0;
        end else if (state == SEQ_RUN && stopZeroExec) begin
            stopLatched <= 1'b1;
        end else if (causeNow.pin || causeNow.supply) begin
            stopLatched <= 1'b0;
        end
    end

    rss_stability_timer #(
        .WAIT_CYCLES(WAIT_CYCLES)
    ) u_wait (
        .clock(clock),
        .sys_rst(sys_rst),
        .run(state == SEQ_WAIT),
        .done(waitDone)
    );

    // sequencer; sys_rst is treated as a power-on reset
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state <= SEQ_HOLD;
        end else begin
            case (state)
                SEQ_RUN: begin
                    if (anyNow) begin
                        state <= SEQ_HOLD;
                    end
                end
                SEQ_HOLD: begin
                    if (!anyNow && !resetReq) begin
                        state <= hardSeen ? SEQ_WAIT : SEQ_INIT;
                    end
                end
                SEQ_WAIT: begin
                    if (anyNow) begin
                        state <= SEQ_HOLD;
                    end else if (waitDone) begin
                        state <= SEQ_INIT;
                    end
                end
                SEQ_INIT: begin
                    state <= anyNow ? SEQ_HOLD : SEQ_RUN;
                end
                default: begin
                    state <= SEQ_HOLD;
                end
            endcase
        end
    end

    assign coreReset = (state == SEQ_HOLD);
    assign oscStop = (state == SEQ_HOLD);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            hardSeen <= 1'b1;
        end else if (state != SEQ_HOLD) begin
            hardSeen <= hardNow;
        end else if (hardNow) begin
            hardSeen <= 1'b1;
        end
    end

    // standby level is caught while running, before reset freezes it
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            standbyAtEntry <= 1'b0;
            retainData <= 1'b0;
        end else begin
            if (state == SEQ_RUN) begin
                standbyAtEntry <= standbyMode;
            end
            retainData <= (state == SEQ_HOLD)
                && (hardSeen || hardNow) && standbyAtEntry;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            fetchEnable <= 1'b0;
            fetchAddr <= START_ADDR;
        end else begin
            fetchEnable <= (state == SEQ_INIT || state == SEQ_RUN)
                && !anyNow;
            if (state == SEQ_INIT) begin
                fetchAddr <= START_ADDR;
            end
        end
    end

    // control flags: reset values win over software writes
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrlFlags.stackDepthPointer <= SP_INIT;
            ctrlFlags.timer1RequestFlag <= 1'b1;
            ctrlFlags.timer1EnableFlag <= 1'b1;
            ctrlFlags.intervalTimerRequestFlag <= 1'b0;
            ctrlFlags.extIntFlag <= 1'b0;
            ctrlFlags.otherControl <= OTHER_INIT;
        end else begin
            ctrlFlags.extIntFlag <= intPin;
            if (state == SEQ_HOLD) begin
                ctrlFlags.stackDepthPointer <= SP_INIT;
                if (hardNow || hardSeen) begin
                    ctrlFlags.timer1RequestFlag <= 1'b1;
                    ctrlFlags.timer1EnableFlag <= 1'b1;
                    ctrlFlags.intervalTimerRequestFlag <= 1'b0;
                    ctrlFlags.otherControl <= OTHER_INIT;
                end
            end else if (wrControl) begin
                ctrlFlags.timer1RequestFlag <= wrData[CTRL_T1REQ_BIT];
                ctrlFlags.timer1EnableFlag <= wrData[CTRL_T1EN_BIT];
                ctrlFlags.intervalTimerRequestFlag <= wrData[CTRL_ITREQ_BIT];
                ctrlFlags.otherControl <=
                    wrData[CTRL_OTHER_MSB:CTRL_OTHER_LSB];
            end
        end
    end

    // peripheral initial values, presented while reset is held
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            timerInit.timer0Modulo <= MODULO_INIT;
            timerInit.timer1Modulo <= MODULO_INIT;
            timerInit.timer0Count <= COUNT_INIT;
            timerInit.timer1Count <= COUNT_INIT;
            timerInit.basicIntervalTimer <= COUNT_INIT;
        end else begin
            if (state == SEQ_HOLD) begin
                timerInit.timer0Modulo <= MODULO_INIT;
                timerInit.timer1Modulo <= MODULO_INIT;
                timerInit.timer0Count <= COUNT_INIT;
                if (hardNow || hardSeen) begin
                    timerInit.timer1Count <= COUNT_INIT;
                end
            end
            // a one-cycle overflow is gone by the time HOLD is entered
            if (causeNow.watchdog) begin
                timerInit.basicIntervalTimer <= BIT_WDT_INIT;
            end
        end
    end

    // sticky cause record; a new cause wins over a write-one clear
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            causeSeen <= '0;
        end else begin
            causeSeen <= causeNow | (causeSeen & ~(wrStatus
                ? rss_cause_type'(wrData[STAT_CAUSE_MSB:STAT_CAUSE_LSB])
                : rss_cause_type'(4'h0)));
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            brownoutEnable <= 1'b0;
        end else if (wrControl) begin
            brownoutEnable <= wrData[CTRL_BROWNOUT_BIT];
        end
    end

    // write channel: address and data accepted in either order
    assign s_axi_awready = !awHave && !s_axi_bvalid;
    assign s_axi_wready = !wHave && !s_axi_bvalid;
    assign wrAddr = awHave ? awAddrQ : s_axi_awaddr;
    assign wrData = wHave ? wDataQ : s_axi_wdata;
    assign wrLane0 = wHave ? wStrbQ[0] : s_axi_wstrb[0];
    assign doWrite = !s_axi_bvalid && (awHave || s_axi_awvalid)
        && (wHave || s_axi_wvalid);
    assign wrSel = regSelect(wrAddr);
    assign wrControl = doWrite && wrLane0 && wrSel[0];
    assign wrStatus = doWrite && wrLane0 && wrSel[1];

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            awHave <= 1'b0;
            wHave <= 1'b0;
            awAddrQ <= '0;
            wDataQ <= ZERO_WORD;
            wStrbQ <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (doWrite) begin
            awHave <= 1'b0;
            wHave <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wrSel == 3'h0)
                ? RESP_SLVERR : RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHave <= 1'b1;
                awAddrQ <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave <= 1'b1;
                wDataQ <= s_axi_wdata;
                wStrbQ <= s_axi_wstrb;
            end
            if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= ZERO_WORD;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= ZERO_WORD;
            case (regSelect(s_axi_araddr))
                3'h1: begin
                    s_axi_rdata[CTRL_BROWNOUT_BIT] <= brownoutEnable;
                    s_axi_rdata[CTRL_T1REQ_BIT] <= ctrlFlags.timer1RequestFlag;
                    s_axi_rdata[CTRL_T1EN_BIT] <= ctrlFlags.timer1EnableFlag;
                    s_axi_rdata[CTRL_ITREQ_BIT] <=
                        ctrlFlags.intervalTimerRequestFlag;
                    s_axi_rdata[CTRL_OTHER_MSB:CTRL_OTHER_LSB] <=
                        ctrlFlags.otherControl;
                end
                3'h2: begin
                    s_axi_rdata[STAT_STATE_MSB:STAT_STATE_LSB] <= state;
                    s_axi_rdata[STAT_CAUSE_MSB:STAT_CAUSE_LSB] <= causeSeen;
                    s_axi_rdata[STAT_RETAIN_BIT] <= retainData;
                end
                3'h4: begin
                    s_axi_rdata[FLAG_SP_MSB:FLAG_SP_LSB] <=
                        ctrlFlags.stackDepthPointer;
                    s_axi_rdata[FLAG_EXTINT_BIT] <= ctrlFlags.extIntFlag;
                    s_axi_rdata[FLAG_BIT_MSB:FLAG_BIT_LSB] <=
                        timerInit.basicIntervalTimer;
                end
                default: begin
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_release_hard;
        state == SEQ_HOLD && !anyNow && !resetReq && hardSeen;
    endsequence
    sequence s_release_soft;
        state == SEQ_HOLD && !anyNow && !resetReq && !hardSeen;
    endsequence

    property p_cause_holds;
        anyNow |=> coreReset && oscStop;
    endproperty
    a_cause_holds: assert property (p_cause_holds)
        else $error("reset cause did not stop the core");

    property p_release_sync;
        $fell(coreReset) |-> !$past(resetReq) && !$past(anyNow);
    endproperty
    a_release_sync: assert property (p_release_sync)
        else $error("reset released while a cause was present");

    property p_hard_wait;
        s_release_hard |=> state == SEQ_WAIT && !fetchEnable;
    endproperty
    a_hard_wait: assert property (p_hard_wait)
        else $error("hard reset release skipped the wait");

    property p_soft_skip;
        s_release_soft ##1 !anyNow |=> state == SEQ_RUN && fetchEnable
            && fetchAddr == START_ADDR;
    endproperty
    a_soft_skip: assert property (p_soft_skip)
        else $error("soft reset did not restart at once");

    property p_wait_start;
        state == SEQ_WAIT && waitDone && !anyNow |=> state == SEQ_INIT
            ##1 (fetchAddr == START_ADDR);
    endproperty
    a_wait_start: assert property (p_wait_start)
        else $error("wait end did not restart at zero");

    property p_supply;
        powerOnDetect || (powerDropDetect && brownoutEnable)
            |=> coreReset;
    endproperty
    a_supply: assert property (p_supply)
        else $error("supply event did not reset");

    property p_drop_off;
        state == SEQ_RUN && powerDropDetect && !brownoutEnable
            && extResetN && !powerOnDetect && !watchdogOverflow
            && !stackFault && !stopLatched |=> !coreReset;
    endproperty
    a_drop_off: assert property (p_drop_off)
        else $error("supply drop reset while disabled");

    property p_hard_init;
        state == SEQ_HOLD && hardNow |=> ctrlFlags.timer1RequestFlag
            && ctrlFlags.timer1EnableFlag
            && !ctrlFlags.intervalTimerRequestFlag
            && ctrlFlags.otherControl == OTHER_INIT
            && ctrlFlags.stackDepthPointer == SP_INIT
            && timerInit.timer1Count == COUNT_INIT
            && timerInit.timer0Modulo == MODULO_INIT;
    endproperty
    a_hard_init: assert property (p_hard_init)
        else $error("hard reset initial values wrong");

    property p_soft_init;
        state == SEQ_HOLD && !hardNow && !hardSeen |=>
            ctrlFlags.stackDepthPointer == SP_INIT
            && $stable(ctrlFlags.otherControl)
            && $stable(timerInit.timer1Count);
    endproperty
    a_soft_init: assert property (p_soft_init)
        else $error("soft reset disturbed kept state");

    property p_wdt_load;
        watchdogOverflow |=>
            timerInit.basicIntervalTimer == BIT_WDT_INIT;
    endproperty
    a_wdt_load: assert property (p_wdt_load)
        else $error("interval timer not loaded on watchdog");

    property p_retain;
        state == SEQ_HOLD && hardSeen && standbyAtEntry |=> retainData;
    endproperty
    a_retain: assert property (p_retain)
        else $error("standby data not kept");

    property p_stop;
        state == SEQ_RUN && stopZeroExec && extResetN && !powerOnDetect
            // the latch lands one edge before the state leaves RUN
            && !powerDropDetect |=> ##1 coreReset ##1 coreReset;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop 0000B did not enter reset state");
endmodule

// >>> rss_stability_timer.sv
// oscillation stability wait counter for the reset sequencer.
// assumes run stays high for the whole wait; dropping it restarts the count.
module rss_stability_timer import rss_pkg::*; #(
    parameter int unsigned WAIT_CYCLES = WAIT_CYCLES_DEFAULT
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic run,
    output logic done
);
    localparam logic [WAIT_CNT_W-1:0] LAST =
        WAIT_CNT_W'(WAIT_CYCLES - 1);

    logic [WAIT_CNT_W-1:0] count;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            count <= '0;
        end else if (!run || done) begin
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end

    assign done = run && (count == LAST);

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    property p_count_step;
        run && !done |=> count == $past(count) + 1'b1;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("wait count did not advance");

    property p_done_at_last;
        done |-> count == LAST && $past(run);
    endproperty
    a_done_at_last: assert property (p_done_at_last)
        else $error("wait ended before the full count");
endmodule

// >>> rss_supply_model.sv
// far-side model: reset pin driver and supply voltage monitor.
// assumes cmd from the bench: bit 0 pin low, 1 power-on, 2 supply drop.
module rss_supply_model (
    input wire logic clock,
    input wire logic [2:0] cmd,
    output logic extResetN,
    output logic powerOnDetect,
    output logic powerDropDetect
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clock) begin
        extResetN <= !cmd[0];
        powerOnDetect <= cmd[1];
        powerDropDetect <= cmd[2];
    end
endmodule

// >>> tb_top.sv
// self-checking bench for the reset source sequencer.
// assumes the supply model on the pins and an AXI4-Lite master task.
module tb_top import rss_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WAIT_N = 16;
    localparam int WAIT_HI = WAIT_N + 8;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic watchdogOverflow = 1'b0, stackFault = 1'b0, intPin = 1'b0;
    logic standbyMode = 1'b0, stopZeroExec = 1'b0;
    logic [2:0] cmd = 3'h0;
    logic extResetN, powerOnDetect, powerDropDetect;
    logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd;
    logic coreReset, oscStop, fetchEnable, retainData;
    logic [11:0] fetchAddr;
    rss_ctrl_type ctrlFlags;
    rss_timer_type timerInit;
    int fails = 0, checkCount = 0, n;

    rss_supply_model PARTNER (.*);
    rss_reset_source_sequencer #(.WAIT_CYCLES(WAIT_N)) DUT (.*);

    always #12.5 clock = ~clock;

    task automatic endSim();
        $display("checks %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // counts edges until the core may fetch again
    task automatic waitRun(output int k);
        k = 0;
        while (fetchEnable !== 1'b1) begin
            @(posedge clock);
            #1;
            k++;
            if (k > 400) begin
                fails++;
                endSim();
            end
        end
    endtask

    task automatic axi(bit wr, logic [ADDR_W-1:0] a, logic [31:0] d);
        int k;
        logic aw, w, ar, fin;
        k = 0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        do begin
            @(negedge clock);
            aw = s_axi_awready;
            w = s_axi_wready;
            ar = s_axi_arready;
            fin = wr ? s_axi_bvalid : s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = wr ? s_axi_bresp : s_axi_rresp;
            @(posedge clock);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (ar) s_axi_arvalid <= 1'b0;
            if (fin) s_axi_bready <= 1'b0;
            if (fin) s_axi_rready <= 1'b0;
            k++;
        end while (!fin && k < 50);
        if (!fin) begin
            fails++;
            endSim();
        end
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        endSim();
    end

    initial begin
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        waitRun(n);
        chk("upWait", n >= WAIT_N && n <= WAIT_N + 8, 1'b1);
        chk("fetchAddr", fetchAddr, START_ADDR);
        chk("sp", ctrlFlags.stackDepthPointer, SP_INIT);
        chk("t1req", ctrlFlags.timer1RequestFlag, 1'b1);
        chk("t1en", ctrlFlags.timer1EnableFlag, 1'b1);
        chk("itreq", ctrlFlags.intervalTimerRequestFlag, 1'b0);
        chk("t0mod", timerInit.timer0Modulo, MODULO_INIT);
        chk("t1mod", timerInit.timer1Modulo, MODULO_INIT);
        chk("t0cnt", timerInit.timer0Count, COUNT_INIT);
        chk("t1cnt", timerInit.timer1Count, COUNT_INIT);
        axi(0, 8'h0c, 32'h0000_0000);
        chk("unmapped", rsp, RESP_SLVERR);
        $display("test power-up done");
        intPin <= 1'b1;
        axi(1, CONTROL_OFFSET, 32'h0000_00f1);
        chk("wrResp", rsp, RESP_OKAY);
        for (int i = 1; i < 3; i++) begin
            @(posedge clock);
            {stackFault, watchdogOverflow} <= 2'(i);
            @(posedge clock);
            {stackFault, watchdogOverflow} <= 2'b00;
            #1;
            chk("oscStop", oscStop, 1'b1);
            chk("keep", ctrlFlags.otherControl, 4'hf);
            chk("extInt", ctrlFlags.extIntFlag, 1'b1);
            chk("bi", timerInit.basicIntervalTimer, BIT_WDT_INIT);
            waitRun(n);
            chk("softFast", n <= 4, 1'b1);
        end
        // soft resets keep the control bits written before them
        axi(0, CONTROL_OFFSET, 32'h0000_0000);
        chk("ctrlRd", rd, 32'h0000_00f1);
        axi(0, FLAGS_OFFSET, 32'h0000_0000);
        chk("flags", rd, {16'h0000, BIT_WDT_INIT, 4'h1, SP_INIT});
        axi(0, STATUS_OFFSET, 32'h0000_0000);
        chk("causes", rd, 32'h0000_00c1);
        $display("test soft resets done");
        for (int k = 0; k < 3; k++) begin
            @(posedge clock);
            standbyMode <= (k == 0);
            cmd <= 3'b001 << k;
            repeat (4) @(posedge clock);
            #1;
            chk("hardHold", coreReset, 1'b1);
            chk("retain", retainData, k == 0);
            @(posedge clock);
            cmd <= 3'h0;
            standbyMode <= 1'b0;
            waitRun(n);
            chk("hardWait", n >= WAIT_N && n <= WAIT_HI, 1'b1);
            chk("cleared", ctrlFlags.otherControl, OTHER_INIT);
        end
        axi(1, CONTROL_OFFSET, 32'h0000_0000);
        cmd <= 3'b100;
        repeat (4) @(posedge clock);
        #1;
        chk("dropOff", coreReset, 1'b0);
        @(posedge clock);
        cmd <= 3'h0;
        // let the model drop its supply flag before the stop strobe
        @(posedge clock);
        stopZeroExec <= 1'b1;
        @(posedge clock);
        stopZeroExec <= 1'b0;
        repeat (WAIT_N + 8) @(posedge clock);
        #1;
        chk("stopHeld", coreReset, 1'b1);
        @(posedge clock);
        cmd <= 3'b001;
        @(posedge clock);
        cmd <= 3'h0;
        waitRun(n);
        chk("stopWake", n >= WAIT_N && n <= WAIT_HI, 1'b1);
        $display("test hard resets done");
        endSim();
    end
endmodule
